// ===== rtl/rfc_flags_ctrl.sv
/*
 * Flags/control register: sticky flags, calibration, hold and latch.
 * Assumes the host drives single-cycle read and write strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module rfc_flags_ctrl
	import rfc_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  rd_i,
	input  wire logic                  wr_i,
	input  wire logic [7:0]            wdata_i,
	output logic      [7:0]            rdata_o,
	input  wire logic                  wdog_zero_i,
	input  wire logic                  alarm_match_i,
	input  wire logic                  supply_low_i,
	input  wire logic [RFC_TIME_W-1:0] time_i,
	output logic      [RFC_TIME_W-1:0] image_o,
	output logic                       calib_o,
	output logic                       hold_o,
	output logic                       load_o
);
	logic       watchdog_timeout_flag_q, watchdog_timeout_flag_d;
	logic       alarm_match_flag_q, alarm_match_flag_d;
	logic       power_loss_flag_q, power_loss_flag_d;
	logic       cal_q, cal_d, hold_q, hold_d, latch_q, latch_d;
	logic       load_q, load_d, cap_q, cap_d;
	logic [7:0] rdata_q, rdata_d;

	////////////////////////////////////////////////////////////////////
	// Sticky flags; software writes never reach them
	always_comb begin
		// Set beats the read clear so no event is lost
		watchdog_timeout_flag_d = wdog_zero_i |
			(watchdog_timeout_flag_q & ~rd_i); // RULE1 RULE4
		alarm_match_flag_d = alarm_match_i |
			(alarm_match_flag_q & ~rd_i); // RULE2 RULE4
		power_loss_flag_d = supply_low_i |
			(power_loss_flag_q & ~rd_i); // RULE3 RULE4
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			watchdog_timeout_flag_q <= 1'b0;
			alarm_match_flag_q      <= 1'b0;
			power_loss_flag_q       <= 1'b0;
		end else begin
			watchdog_timeout_flag_q <= watchdog_timeout_flag_d;
			alarm_match_flag_q      <= alarm_match_flag_d;
			power_loss_flag_q       <= power_loss_flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control bits and their one-cycle strobes
	always_comb begin
		cal_d   = wr_i ? wdata_i[RFC_CAL_BIT] : cal_q; // RULE5
		hold_d  = wr_i ? wdata_i[RFC_HOLD_BIT] : hold_q; // RULE6
		latch_d = wr_i ? wdata_i[RFC_LATCH_BIT] : latch_q;
		load_d  = hold_q & ~hold_d; // RULE8
		cap_d   = ~latch_q & latch_d; // RULE10
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cal_q   <= RFC_RESET[RFC_CAL_BIT];
			hold_q  <= RFC_RESET[RFC_HOLD_BIT];
			latch_q <= RFC_RESET[RFC_LATCH_BIT];
			load_q  <= 1'b0;
			cap_q   <= 1'b0;
		end else begin
			cal_q   <= cal_d;
			hold_q  <= hold_d;
			latch_q <= latch_d;
			load_q  <= load_d;
			cap_q   <= cap_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data, held until the next read
	always_comb begin
		rdata_d = rdata_q;
		if (rd_i) begin
			rdata_d = {watchdog_timeout_flag_q, alarm_match_flag_q,
				power_loss_flag_q, 2'b00, cal_q, hold_q, latch_q};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= RFC_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Image register is one cycle behind the capture pulse
	rfc_snap u_snap (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.cap_i   (cap_q), // RULE9
		.time_i  (time_i),
		.image_o (image_o)
	);

	assign rdata_o = rdata_q;
	assign calib_o = cal_q;
	assign hold_o  = hold_q; // RULE7
	assign load_o  = load_q;

	////////////////////////////////////////////////////////////////////
	// All checks run on the one clock and sleep through reset
	default clocking dcb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_WDOG_SET: assert property ( // RULE1
		wdog_zero_i
		|=> watchdog_timeout_flag_q)
		else $error("watchdog flag not set");

	AST_ALARM_SET: assert property ( // RULE2
		alarm_match_i
		|=> alarm_match_flag_q)
		else $error("alarm flag not set");

	AST_PWR_SET: assert property ( // RULE3
		supply_low_i
		|=> power_loss_flag_q)
		else $error("power flag not set");

	AST_WDOG_KEEP: assert property ( // RULE1
		watchdog_timeout_flag_q && !rd_i
		|=> watchdog_timeout_flag_q)
		else $error("watchdog flag lost");

	AST_RD_CLR: assert property ( // RULE4
		rd_i && !wdog_zero_i
		|=> !watchdog_timeout_flag_q)
		else $error("flag not cleared by read");

	AST_RD_CLR_ALARM: assert property ( // RULE4
		rd_i && !alarm_match_i
		|=> !alarm_match_flag_q)
		else $error("alarm flag not cleared by read");

	AST_RD_CLR_PWR: assert property ( // RULE4
		rd_i && !supply_low_i
		|=> !power_loss_flag_q)
		else $error("power flag not cleared by read");

	AST_WDOG_CAUSE: assert property ( // RULE4
		!watchdog_timeout_flag_q && !wdog_zero_i
		|=> !watchdog_timeout_flag_q)
		else $error("watchdog flag set without event");

	AST_ALARM_CAUSE: assert property ( // RULE4
		!alarm_match_flag_q && !alarm_match_i
		|=> !alarm_match_flag_q)
		else $error("alarm flag set without event");

	AST_PWR_CAUSE: assert property ( // RULE4
		!power_loss_flag_q && !supply_low_i
		|=> !power_loss_flag_q)
		else $error("power flag set without event");

	AST_RDATA: assert property ( // RULE4
		rd_i
		|=> rdata_o == {$past(watchdog_timeout_flag_q),
			$past(alarm_match_flag_q), $past(power_loss_flag_q),
			2'b00, $past(cal_q), $past(hold_q), $past(latch_q)})
		else $error("read data wrong");

	AST_RDATA_KEEP: assert property ( // RULE4
		!rd_i
		|=> $stable(rdata_o))
		else $error("read data changed without read");

	AST_CAL: assert property ( // RULE5
		wr_i
		|=> calib_o == $past(wdata_i[RFC_CAL_BIT]))
		else $error("calibration bit wrong");

	AST_CAL_KEEP: assert property ( // RULE5
		!wr_i
		|=> $stable(calib_o))
		else $error("calibration bit changed without write");

	AST_HOLD: assert property ( // RULE6
		wr_i && wdata_i[RFC_HOLD_BIT]
		|=> hold_o)
		else $error("hold not set");

	AST_HOLD_CLR: assert property ( // RULE6
		wr_i && !wdata_i[RFC_HOLD_BIT]
		|=> !hold_o)
		else $error("hold not cleared");

	AST_LOAD: assert property ( // RULE8
		$fell(hold_q)
		|-> load_o)
		else $error("no load after hold clear");

	AST_LOAD_ONLY: assert property ( // RULE8
		load_o
		|-> $past(hold_q) && !hold_q)
		else $error("load without hold clear");

	AST_LOAD_PULSE: assert property ( // RULE8
		load_o
		|=> !load_o)
		else $error("load longer than one cycle");

	AST_LATCH: assert property ( // RULE10
		wr_i
		|=> latch_q == $past(wdata_i[RFC_LATCH_BIT]))
		else $error("latch bit wrong");

	AST_CAP: assert property ( // RULE9
		$rose(latch_q)
		|=> ##1 image_o == $past(time_i, 2))
		else $error("image not captured");

	AST_IMG_KEEP: assert property ( // RULE9
		!cap_q
		|=> $stable(image_o))
		else $error("image changed without capture");

	AST_NO_RECAP: assert property ( // RULE10
		latch_q && $past(latch_q)
		|=> !cap_q)
		else $error("capture without rising edge");

	AST_CAP_EDGE: assert property ( // RULE10
		cap_q
		|-> latch_q && !$past(latch_q))
		else $error("capture strobe off the latch edge");
endmodule // rfc_flags_ctrl
`default_nettype wire

// ===== rtl/rfc_pkg.sv
/*
 * Constants for the flags/control register logic of the real-time clock.
 * Assumes a byte-wide register port with read and write strobes.
 */
// Contract
// RULE1: Watchdog reaching zero sets its flag
// RULE2: Alarm match on unmasked fields sets flag
// RULE3: Supply below switchover sets power flag
// RULE4: Register read clears flags; flags unwritable
// RULE5: Tuning bit selects calibration mode
// RULE6: Hold bit set freezes timekeeping updates
// RULE7: Host sets hold, writes time, clears
// RULE8: Hold cleared loads time into counters
// RULE9: Latch bit copies time into holding image
// RULE10: Capture only on latch rising edge
// RULE11: Host returns latch to zero first
package rfc_pkg;
	localparam int          RFC_WDOG_BIT  = 7;
	localparam int          RFC_ALARM_BIT = 6;
	localparam int          RFC_PWR_BIT   = 5;
	localparam int          RFC_CAL_BIT   = 2;
	localparam int          RFC_HOLD_BIT  = 1;
	localparam int          RFC_LATCH_BIT = 0;
	localparam logic [7:0]  RFC_RESET     = 8'h00;
	localparam int          RFC_TIME_W    = 64;
endpackage : rfc_pkg

// ===== rtl/rfc_snap.sv
/*
 * Holding image of the timekeeping registers.
 * Assumes the capture strobe is one clock long.
 */
`timescale 1ns/100ps
`default_nettype none
module rfc_snap
	import rfc_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  cap_i,
	input  wire logic [RFC_TIME_W-1:0] time_i,
	output var  logic [RFC_TIME_W-1:0] image_o
);
	logic [RFC_TIME_W-1:0] img_q;
	logic [RFC_TIME_W-1:0] img_d;

	always_comb begin
		img_d = cap_i ? time_i : img_q; // RULE9
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			img_q <= '0;
		end else begin
			img_q <= img_d;
		end
	end

	assign image_o = img_q;
endmodule // rfc_snap
`default_nettype wire

// ===== sim/rfc_host.sv
/* Host model: drives the register read and write strobes.
   Assumes callers start after reset release. */
`timescale 1ns/100ps
`default_nettype none
module rfc_host (
	input  wire logic       clk_i,
	output var  logic       rd_o,
	output var  logic       wr_o,
	output var  logic [7:0] wdata_o
);
	initial begin
		rd_o    = 1'b0;
		wr_o    = 1'b0;
		wdata_o = 8'h00;
	end
////////////////////////////////////////////////////////////////////////
	// Data is inverted when idle so a stale byte never looks valid
	task put(input logic [7:0] v);
		@(posedge clk_i) wr_o <= 1'b1;
		wdata_o <= v;
		@(posedge clk_i) wr_o <= 1'b0;
		wdata_o <= ~v;
	endtask
	task get;
		@(posedge clk_i) rd_o <= 1'b1;
		@(posedge clk_i) rd_o <= 1'b0;
	endtask
endmodule // rfc_host
`default_nettype wire

// ===== sim/testbench.sv
/* Self-checking bench for the flags/control logic.
   Assumes the host model drives all register strobes. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import rfc_pkg::*;
	int                    errors = 0;
	int                    tests_run = 0;
	logic                  clk_i = 1'b0;
	logic                  rst_n_i = 1'b0;
	logic [2:0]            evt;
	logic [RFC_TIME_W-1:0] tm;
	logic                  rd_i, wr_i, calib_o, hold_o, load_o;
	logic [7:0]            wdata_i, rdata_o;
	logic [RFC_TIME_W-1:0] image_o;
	always #5 clk_i = ~clk_i;
	rfc_host i_rfc_host (.clk_i, .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i));
	rfc_flags_ctrl i_rfc_flags_ctrl (.clk_i, .rst_n_i, .rd_i, .wr_i,
		.wdata_i, .rdata_o, .wdog_zero_i(evt[2]), .alarm_match_i(evt[1]),
		.supply_low_i(evt[0]), .time_i(tm), .image_o, .calib_o, .hold_o,
		.load_o);
////////////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] g, input logic [63:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task give_verdict;
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////
	// Writing ones to the flag bits must not set them
	task t_flags;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i) evt <= 3'h1 << i;
			@(posedge clk_i) evt <= 3'h0;
			i_rfc_host.put(8'hE0);
			i_rfc_host.get;
			#1 chk(rdata_o, {3'h1 << i, 5'h00});
			i_rfc_host.get;
			#1 chk(rdata_o, 8'h00);
		end
	endtask
	task t_ctrl;
		i_rfc_host.put(8'h04);
		#1 chk(calib_o, 1'b1);
		i_rfc_host.put(8'h02);
		#1 chk({calib_o, hold_o, load_o}, 3'h2);
		i_rfc_host.put(8'h00);
		#1 chk({hold_o, load_o}, 2'h1);
		@(posedge clk_i) #1 chk(load_o, 1'b0);
	endtask
	task t_latch;
		i_rfc_host.put(8'h01);
		repeat (3) @(posedge clk_i);
		#1 chk(image_o, 64'h0123456789ABCDEF);
		@(posedge clk_i) tm <= ~tm;
		repeat (3) @(posedge clk_i);
		#1 chk(image_o, 64'h0123456789ABCDEF);
		i_rfc_host.put(8'h00);
		i_rfc_host.put(8'h01);
		repeat (3) @(posedge clk_i);
		#1 chk(image_o, 64'hFEDCBA9876543210);
	endtask
////////////////////////////////////////////////////////////////////////
	initial begin
		evt = 3'h0;
		tm  = 64'h0123456789ABCDEF;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_flags;
		t_ctrl;
		t_latch;
		give_verdict;
	end
	// Tests need about 53 cycles; fifteen times that is a hang
	initial begin
		#8000;
		errors++;
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
